// file: rtl/ioas_top.sv
`timescale 1ns/1ns
// What this block does
// - Address is ten times tens switch plus ones switch.
// - Addresses above 77 are invalid; each module needs a distinct one.
// - After power-up power light blinks tens-digit times.
// - After power-up comm light blinks ones-digit times.
// - When ready, power light toggles slowly as heartbeat.
// - Once ready, comm light stays lit while module transmits.
// - No heartbeat before the module is operational.
// - Twelve relay lights, each lit while its relay is energised.
// - Twenty-four input lights, each lit while its input is live.
// - Shared bus; controller reaches module by its own address.
module ioas_top #(
  parameter int unsigned BLINK_HALF_CYC = ioas_pkg::BLINK_HALF_CYC,
  parameter int unsigned GAP_CYC        = ioas_pkg::GAP_CYC,
  parameter int unsigned BEAT_HALF_CYC  = ioas_pkg::BEAT_HALF_CYC,
  parameter int unsigned RELAY_N        = ioas_pkg::RELAY_N,
  parameter int unsigned INPUT_N        = ioas_pkg::INPUT_N
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Address switches
  input  wire logic [ioas_pkg::DIGIT_W-1:0] ones_digit_switch,
  input  wire logic [ioas_pkg::DIGIT_W-1:0] tens_digit_switch,
  // Bus side
  input  wire logic                        tx_active,
  // Plant I/O state
  input  wire logic [RELAY_N-1:0]          relay_on,
  input  wire logic [INPUT_N-1:0]          input_live,
  // Address report
  output logic [ioas_pkg::ADDR_W-1:0]      bus_address,
  output logic                             address_valid,
  output logic                             ready,
  // Indicators
  output logic                             power_led,
  output logic                             comm_led,
  output logic [RELAY_N-1:0]               relay_led,
  output logic [INPUT_N-1:0]               input_led
);

  ioas_pkg::ioas_state_t             st_r, st_nxt;
  logic [ioas_pkg::DIGIT_W-1:0]      tens_r, tens_nxt;
  logic [ioas_pkg::DIGIT_W-1:0]      ones_r, ones_nxt;
  logic [ioas_pkg::TMR_W-1:0]        tmr_r, tmr_nxt;
  logic                              beat_r, beat_nxt;
  logic                              start_tens, start_ones;
  logic                              tens_led, ones_led;
  logic                              tens_done, ones_done;
  logic [ioas_pkg::ADDR_W-1:0]       addr_nxt;
  logic                              power_nxt, comm_nxt;
  logic                              valid_nxt, ready_nxt;

  // ----------------------------------------------------------------
  // Blink groups
  // ----------------------------------------------------------------
  ioas_blinker #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_tens (
    .clk   (clk),
    .rst   (rst),
    .start (start_tens),
    .count (tens_r),
    .led   (tens_led),
    .done  (tens_done)
  );

  ioas_blinker #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_ones (
    .clk   (clk),
    .rst   (rst),
    .start (start_ones),
    .count (ones_r),
    .led   (ones_led),
    .done  (ones_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    tens_nxt   = tens_r;
    ones_nxt   = ones_r;
    tmr_nxt    = tmr_r;
    beat_nxt   = beat_r;
    start_tens = 1'b0;
    start_ones = 1'b0;
    unique case (st_r)
      ioas_pkg::IOAS_LATCH: begin
        // Switches are caught once, after reset release
        tens_nxt   = tens_digit_switch;
        ones_nxt   = ones_digit_switch;
        st_nxt     = ioas_pkg::IOAS_TENS;
      end
      ioas_pkg::IOAS_TENS: begin
        start_tens = (tmr_r == '0);
        tmr_nxt    = ioas_pkg::TMR_W'(1);
        if (tens_done) begin
          tmr_nxt = ioas_pkg::TMR_W'(GAP_CYC - 1);
          st_nxt  = ioas_pkg::IOAS_GAP;
        end
      end
      ioas_pkg::IOAS_GAP: begin
        if (tmr_r == '0) begin
          start_ones = 1'b1;
          st_nxt     = ioas_pkg::IOAS_ONES;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      ioas_pkg::IOAS_ONES: begin
        if (ones_done) begin
          tmr_nxt = ioas_pkg::TMR_W'(BEAT_HALF_CYC - 1);
          beat_nxt = 1'b1;
          st_nxt  = ioas_pkg::IOAS_RUN;
        end
      end
      ioas_pkg::IOAS_RUN: begin
        if (tmr_r == '0) begin
          tmr_nxt  = ioas_pkg::TMR_W'(BEAT_HALF_CYC - 1);
          beat_nxt = ~beat_r;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Output values
  // ----------------------------------------------------------------
  always_comb begin
    addr_nxt = ioas_pkg::ADDR_W'(tens_r * ioas_pkg::TENS_SCALE)
             + ioas_pkg::ADDR_W'(ones_r);
    power_nxt = (st_nxt == ioas_pkg::IOAS_RUN) ? beat_nxt : tens_led;
    comm_nxt  = (st_nxt == ioas_pkg::IOAS_RUN) ? tx_active : ones_led;
    valid_nxt = (st_r != ioas_pkg::IOAS_LATCH)
              && (tens_r <= 4'h9) && (ones_r <= 4'h9)
              && (addr_nxt <= ioas_pkg::ADDR_MAX);
    ready_nxt = (st_nxt == ioas_pkg::IOAS_RUN);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r          <= ioas_pkg::IOAS_LATCH;
      tens_r        <= '0;
      ones_r        <= '0;
      tmr_r         <= '0;
      beat_r        <= 1'b0;
      bus_address   <= '0;
      address_valid <= 1'b0;
      ready         <= 1'b0;
      power_led     <= 1'b0;
      comm_led      <= 1'b0;
    end else begin
      st_r          <= st_nxt;
      tens_r        <= tens_nxt;
      ones_r        <= ones_nxt;
      tmr_r         <= tmr_nxt;
      beat_r        <= beat_nxt;
      bus_address   <= addr_nxt;
      address_valid <= valid_nxt;
      ready         <= ready_nxt;
      power_led     <= power_nxt;
      comm_led      <= comm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Channel indicators
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < RELAY_N; gi++) begin : g_relay
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          relay_led[gi] <= 1'b0;
        end else begin
          relay_led[gi] <= relay_on[gi];
        end
      end
    end
    for (gi = 0; gi < INPUT_N; gi++) begin : g_input
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          input_led[gi] <= 1'b0;
        end else begin
          input_led[gi] <= input_live[gi];
        end
      end
    end
  endgenerate

endmodule

// file: rtl/ioas_pkg.sv
package ioas_pkg;

  // ----------------------------------------------------------------
  // Address
  // ----------------------------------------------------------------
  localparam int unsigned DIGIT_W    = 4;
  localparam int unsigned ADDR_W     = 7;
  localparam logic [6:0]  ADDR_MAX   = 7'h4D;
  localparam logic [6:0]  TENS_SCALE = 7'h0A;

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  localparam int unsigned RELAY_N = 12;
  localparam int unsigned INPUT_N = 24;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned GAP_MS        = 1000;
  localparam int unsigned BEAT_HALF_MS  = 1000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned GAP_CYC        = GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned BEAT_HALF_CYC  = BEAT_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W          = 28;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOAS_LATCH,
    IOAS_TENS,
    IOAS_GAP,
    IOAS_ONES,
    IOAS_RUN
  } ioas_state_t;

endpackage

// file: rtl/ioas_blinker.sv
`timescale 1ns/1ns
// Emits a given number of on/off blink pulses, then reports done.
module ioas_blinker #(
  parameter int unsigned HALF_CYC = 25_000_000
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Control
  input  wire logic                        start,
  input  wire logic [ioas_pkg::DIGIT_W-1:0] count,
  // Status
  output logic                             led,
  output logic                             done
);

  logic [ioas_pkg::TMR_W-1:0]   tmr_r, tmr_nxt;
  logic [ioas_pkg::DIGIT_W:0]   half_r, half_nxt;
  logic                         busy_r, busy_nxt;
  logic                         done_nxt;
  logic                         led_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    tmr_nxt  = tmr_r;
    half_nxt = half_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start) begin
      busy_nxt = (count != '0);
      done_nxt = (count == '0);
      half_nxt = {count, 1'b0};
      tmr_nxt  = ioas_pkg::TMR_W'(HALF_CYC - 1);
    end else if (busy_r) begin
      if (tmr_r == '0) begin
        half_nxt = half_r - 1'b1;
        tmr_nxt  = ioas_pkg::TMR_W'(HALF_CYC - 1);
        if (half_r == (ioas_pkg::DIGIT_W+1)'(1)) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end else begin
        tmr_nxt = tmr_r - 1'b1;
      end
    end
    // Odd half counts are the lit phases
    led_nxt = busy_nxt & half_nxt[0];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_r  <= '0;
      half_r <= '0;
      busy_r <= 1'b0;
      led    <= 1'b0;
      done   <= 1'b0;
    end else begin
      tmr_r  <= tmr_nxt;
      half_r <= half_nxt;
      busy_r <= busy_nxt;
      led    <= led_nxt;
      done   <= done_nxt;
    end
  end

endmodule

// file: verif/ioas_ctrl_model.sv
`timescale 1ns/1ns
// Controller side: polls the module, which then sends len cycles
module ioas_ctrl_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Poll request
  input  wire logic       go,
  input  wire logic [7:0] len,
  // Module answer in progress
  output logic            tx_active
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  always_comb begin
    cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
    if (go) begin
      cnt_nxt = len;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tx_active = (cnt_r != 8'h00);
endmodule

// file: verif/ioas_chk_props.sv
`timescale 1ns/1ns
module ioas_chk #(
  parameter int unsigned RELAY_N = 12,
  parameter int unsigned INPUT_N = 24
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Inputs
  input wire logic [3:0]         ones_digit_switch,
  input wire logic [3:0]         tens_digit_switch,
  input wire logic               tx_active,
  input wire logic [RELAY_N-1:0] relay_on,
  input wire logic [INPUT_N-1:0] input_live,
  // Outputs
  input wire logic [6:0]         bus_address,
  input wire logic               address_valid,
  input wire logic               ready,
  input wire logic               power_led,
  input wire logic               comm_led,
  input wire logic [RELAY_N-1:0] relay_led,
  input wire logic [INPUT_N-1:0] input_led
);
  logic       lat_r;
  logic [7:0] adr_r;
  logic       ok_r;

  // Switch value seen at the first edge after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_r <= 1'b0;
      adr_r <= 8'h00;
      ok_r  <= 1'b0;
    end else if (!lat_r) begin
      lat_r <= 1'b1;
      adr_r <= tens_digit_switch * 8'h0A + ones_digit_switch;
      ok_r  <= tens_digit_switch <= 4'h9 && ones_digit_switch <= 4'h9 &&
               tens_digit_switch * 8'h0A + ones_digit_switch <= 8'h4D;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  addr_value_a: assert property (ready && ok_r |->
    bus_address == adr_r[6:0]) else $error("bus address wrong");
  addr_valid_a: assert property (ready |-> address_valid == ok_r)
    else $error("address valid flag wrong");
  tens_pulse_a: assert property (!ready && $rose(power_led)
    |-> ##[1:7] !power_led) else $error("power blink too long");
  ones_pulse_a: assert property (!ready && $rose(comm_led)
    |-> ##[1:7] !comm_led) else $error("comm blink too long");
  beat_rate_a: assert property (ready && $changed(power_led)
    |=> $stable(power_led)[*4] ##[1:7] $changed(power_led))
    else $error("heartbeat period wrong");
  comm_tx_a: assert property (ready && $past(ready) |->
    comm_led == $past(tx_active)) else $error("comm light not tx");
  beat_start_a: assert property ($rose(ready) |-> power_led)
    else $error("heartbeat not started with ready");
  relay_led_a: assert property (!$past(rst) |->
    relay_led == $past(relay_on)) else $error("relay light wrong");
  input_led_a: assert property (!$past(rst) |->
    input_led == $past(input_live)) else $error("input light wrong");
  group_gap_a: assert property (!ready |-> !(power_led && comm_led))
    else $error("blink groups overlap");

  boot_done_c: cover property ($rose(ready));
  tx_seen_c: cover property (ready && tx_active ##1 comm_led);
  bad_addr_c: cover property (ready && !address_valid);
endmodule

bind ioas_top ioas_chk #(.RELAY_N(RELAY_N), .INPUT_N(INPUT_N)) u_chk (
  .clk(clk), .rst(rst), .ones_digit_switch(ones_digit_switch),
  .tens_digit_switch(tens_digit_switch), .tx_active(tx_active),
  .relay_on(relay_on), .input_live(input_live),
  .bus_address(bus_address), .address_valid(address_valid),
  .ready(ready), .power_led(power_led), .comm_led(comm_led),
  .relay_led(relay_led), .input_led(input_led));

// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  ones_sw = 4'h0;
  logic [3:0]  tens_sw = 4'h0;
  logic [11:0] relay_on = 12'h000;
  logic [23:0] input_live = 24'h000000;
  logic        go = 1'b0;
  logic [7:0]  len = 8'h00;
  logic        tx_active, address_valid, ready, power_led, comm_led;
  logic [6:0]  bus_address;
  logic [11:0] relay_led;
  logic [23:0] input_led;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #5 clk = ~clk;

  ioas_top #(.BLINK_HALF_CYC(4), .GAP_CYC(10), .BEAT_HALF_CYC(8)) dut (
    .clk(clk), .rst(rst), .ones_digit_switch(ones_sw),
    .tens_digit_switch(tens_sw), .tx_active(tx_active),
    .relay_on(relay_on), .input_live(input_live),
    .bus_address(bus_address), .address_valid(address_valid),
    .ready(ready), .power_led(power_led), .comm_led(comm_led),
    .relay_led(relay_led), .input_led(input_led));
  ioas_ctrl_model peer (.clk(clk), .rst(rst), .go(go), .len(len),
    .tx_active(tx_active));

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Power up with given switches; later switch moves must be ignored
  task automatic boot(input logic [3:0] t, o, input logic v, tx);
    int pr, cr, n, pf, cf;
    logic pp, cp;
    pr = 0;
    cr = 0;
    n = 0;
    pf = 0;
    cf = 0;
    rst = 1'b1;
    tens_sw = t;
    ones_sw = o;
    len = 8'hC8;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    pp = power_led;
    cp = comm_led;
    while (ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
      go = tx && n == 2;
      if (n == 3) begin
        tens_sw = ~t;
        ones_sw = ~o;
      end
      if (!ready && power_led && !pp) pr++;
      if (!ready && comm_led && !cp) cr++;
      if (!ready && !power_led && pp) pf = n;
      if (!ready && comm_led && !cp && cf == 0) cf = n;
      pp = power_led;
      cp = comm_led;
    end
    cmp("ready", 1, 32'(ready));
    cmp("address valid", 32'(v), 32'(address_valid));
    if (v) begin
      cmp("address", 32'(t) * 10 + 32'(o), 32'(bus_address));
      cmp("tens blinks", 32'(t), pr);
      cmp("ones blinks", 32'(o), cr);
      if (t != 4'h0 && o != 4'h0) begin
        cmp("group pause", 1, 32'(cf - pf >= 10));
      end
    end
  endtask

  task automatic beat;
    int tg;
    logic pp;
    tg = 0;
    pp = power_led;
    repeat (64) begin
      @(negedge clk);
      if (power_led !== pp) tg++;
      pp = power_led;
    end
    cmp("beat toggles", 8, tg);
  endtask

  task automatic talk;
    logic pt;
    len = 8'h05;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    pt = tx_active;
    repeat (12) begin
      @(negedge clk);
      cmp("comm follows tx", 32'(pt), 32'(comm_led));
      pt = tx_active;
    end
  endtask

  task automatic leds;
    for (int i = 0; i < 6; i++) begin
      relay_on = (12'h001 << (2 * i)) ^ 12'hA5A;
      input_live = ~(24'h000001 << (4 * i));
      @(negedge clk);
      cmp("relay lights", 32'(relay_on), 32'(relay_led));
      cmp("input lights", 32'(input_live), 32'(input_led));
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial begin
    @(negedge clk);
    boot(4'h0, 4'h0, 1'b1, 1'b1);
    boot(4'h7, 4'h7, 1'b1, 1'b0);
    boot(4'h7, 4'h8, 1'b0, 1'b0);
    boot(4'h8, 4'h0, 1'b0, 1'b0);
    boot(4'h2, 4'hC, 1'b0, 1'b0);
    boot(4'h0, 4'h3, 1'b1, 1'b0);
    boot(4'h1, 4'h0, 1'b1, 1'b0);
    beat;
    talk;
    leds;
    tally_and_finish;
  end
endmodule
